// File: common/sacc_pkg.sv
// Constants and types for the SAR converter configuration and control block
package sacc_pkg;
  localparam logic [7:0] SACC_CTL_ADDR = 8'he8;
  localparam logic [7:0] SACC_CFG_ADDR = 8'hbc;
  localparam logic [7:0] SACC_CTL_RESET = 8'h00;
  localparam logic [7:0] SACC_CFG_RESET = 8'h00;
  // Configuration field positions
  localparam int SACC_CFG_PERIOD_MSB = 7;
  localparam int SACC_CFG_PERIOD_LSB = 5;
  localparam logic [7:0] SACC_CFG_WRITE_MASK = 8'he7;
  // Control bit positions
  localparam int SACC_CTL_ENABLE = 7;
  localparam int SACC_CTL_TRACK_MODE = 6;
  localparam int SACC_CTL_DONE = 5;
  localparam int SACC_CTL_BUSY = 4;
  localparam int SACC_CTL_START_MSB = 3;
  localparam int SACC_CTL_START_LSB = 2;
  localparam int SACC_CTL_WINDOW = 1;
  localparam int SACC_CTL_LEFT_JUST = 0;
  // Start mode where a busy-bit write launches the conversion
  localparam logic [1:0] SACC_START_BY_WRITE = 2'h0;
  // Timing in SAR clocks; settling time in system clocks
  localparam logic [4:0] SACC_TRACK_SAR_CLKS = 5'h03;
  localparam logic [4:0] SACC_CONV_SAR_CLKS = 5'h10;
  localparam int SACC_SETTLE_CYCLES = 16;

  typedef enum logic [1:0] {SACC_IDLE, SACC_TRACK, SACC_CONVERT} sacc_state_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic [3:0] divCnt;
    logic sarClkEn;
    sacc_state_t state;
    logic [4:0] tickCnt;
    logic [7:0] rdData;
    logic [2:0] gainLog2;
    logic tracking;
  } sacc_regs_t;

  // SAR clock period in system clocks for a period code
  function automatic logic [4:0] sacc_div_period(input logic [2:0] code);
    if (code[2]) begin
      return 5'h10;
    end
    return 5'(5'h01 << code[1:0]);
  endfunction : sacc_div_period

  // Amplifier gain as a power of two for a gain code
  function automatic logic [2:0] sacc_gain_log2(input logic [2:0] code);
    if (code[2]) begin
      return 3'h4;
    end
    return {1'b0, code[1:0]};
  endfunction : sacc_gain_log2
endpackage : sacc_pkg

// File: hdl/sacc_control.sv
// SAR converter configuration and control registers with conversion sequencer
`timescale 1ns/1ps
//
// Behaviour
// RULE1: Codes 000..011 divide clock by 1,2,4,8
// RULE2: Period MSB set divides clock by 16
// RULE3: Software keeps SAR clock at most 2MHz
// RULE4: Configuration bits 4-3 read zero, ignore writes
// RULE5: Gain code selects gain 1,2,4,8 or 16
// RULE6: Tracking-mode clear: track continuously unless converting
// RULE7: Control resets zero, bit addressable, busy starts
module sacc_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Special-function register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWe,
  input wire logic sfrRe,
  output logic [7:0] sfrRdData,
  // Bit access to the control register
  input wire logic [2:0] ctlBitSel,
  input wire logic ctlBitData,
  input wire logic ctlBitWe,
  // Converter side events
  input wire logic extStart,
  input wire logic windowHit,
  // Converter controls
  output logic sarClkEn,
  output logic [2:0] gainLog2,
  output logic tracking,
  output logic converting,
  output logic leftJustify
);
  import sacc_pkg::*;

  sacc_regs_t r;
  sacc_regs_t n;
  logic [7:0] ctlWr;
  logic ctlWrHit;
  logic startReq;

  always_comb begin
    n = r;
    ctlWrHit = (sfrWe && sfrAddr == SACC_CTL_ADDR) || ctlBitWe;
    ctlWr = r.ctl;
    if (sfrWe && sfrAddr == SACC_CTL_ADDR) begin
      ctlWr = sfrWrData;
    end else if (ctlBitWe) begin // RULE7
      ctlWr[ctlBitSel] = ctlBitData;
    end
    // Busy is owned by the sequencer; in the write start mode a one written there is a start request
    startReq = r.ctl[SACC_CTL_ENABLE] && r.state == SACC_IDLE &&
      ((r.ctl[SACC_CTL_START_MSB:SACC_CTL_START_LSB] == SACC_START_BY_WRITE &&
        ctlWrHit && ctlWr[SACC_CTL_BUSY]) ||
       (r.ctl[SACC_CTL_START_MSB:SACC_CTL_START_LSB] != SACC_START_BY_WRITE &&
        extStart)); // RULE7
    if (ctlWrHit) begin
      n.ctl = ctlWr;
      n.ctl[SACC_CTL_BUSY] = r.ctl[SACC_CTL_BUSY];
    end
    if (sfrWe && sfrAddr == SACC_CFG_ADDR) begin
      n.cfg = sfrWrData & SACC_CFG_WRITE_MASK; // RULE4
    end
    // SAR clock divider
    if (5'(r.divCnt) + 5'h01 >=
        sacc_div_period(r.cfg[SACC_CFG_PERIOD_MSB:SACC_CFG_PERIOD_LSB])) begin
      n.divCnt = 4'h0; // RULE1 RULE2
      n.sarClkEn = 1'b1;
    end else begin
      n.divCnt = r.divCnt + 4'h1;
      n.sarClkEn = 1'b0;
    end
    n.gainLog2 = sacc_gain_log2(r.cfg[2:0]); // RULE5
    // Sequencer
    case (r.state)
      SACC_IDLE: begin
        if (startReq) begin
          n.ctl[SACC_CTL_BUSY] = 1'b1;
          n.tickCnt = 5'h00;
          n.state = r.ctl[SACC_CTL_TRACK_MODE] ? SACC_TRACK : SACC_CONVERT;
        end
      end
      SACC_TRACK: begin
        if (r.sarClkEn) begin
          n.tickCnt = r.tickCnt + 5'h01;
          if (r.tickCnt + 5'h01 == SACC_TRACK_SAR_CLKS) begin
            n.tickCnt = 5'h00;
            n.state = SACC_CONVERT;
          end
        end
      end
      SACC_CONVERT: begin
        if (r.sarClkEn) begin
          n.tickCnt = r.tickCnt + 5'h01;
          if (r.tickCnt + 5'h01 == SACC_CONV_SAR_CLKS) begin
            n.tickCnt = 5'h00;
            n.state = SACC_IDLE;
            n.ctl[SACC_CTL_BUSY] = 1'b0;
            // Hardware set wins over a same-cycle software clear
            n.ctl[SACC_CTL_DONE] = 1'b1;
            n.ctl[SACC_CTL_WINDOW] = r.ctl[SACC_CTL_WINDOW] | n.ctl[SACC_CTL_WINDOW] | windowHit;
          end
        end
      end
      default: begin
        n.state = SACC_IDLE;
      end
    endcase
    // Disabling the converter abandons a conversion in flight
    if (!n.ctl[SACC_CTL_ENABLE]) begin
      n.state = SACC_IDLE;
      n.ctl[SACC_CTL_BUSY] = 1'b0;
    end
    n.tracking = n.ctl[SACC_CTL_ENABLE] &&
      ((!n.ctl[SACC_CTL_TRACK_MODE] && n.state == SACC_IDLE) ||
       n.state == SACC_TRACK); // RULE6
    if (sfrRe) begin
      case (sfrAddr)
        SACC_CTL_ADDR: n.rdData = r.ctl;
        SACC_CFG_ADDR: n.rdData = r.cfg & SACC_CFG_WRITE_MASK; // RULE4
        default: n.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{cfg: SACC_CFG_RESET, ctl: SACC_CTL_RESET, divCnt: 4'h0, sarClkEn: 1'b0,
             state: SACC_IDLE, tickCnt: 5'h00, rdData: 8'h00, gainLog2: 3'h0,
             tracking: 1'b0}; // RULE7
    end else begin
      r <= n;
    end
  end

  assign sfrRdData = r.rdData;
  assign sarClkEn = r.sarClkEn;
  assign gainLog2 = r.gainLog2;
  assign tracking = r.tracking;
  assign converting = r.ctl[SACC_CTL_BUSY];
  assign leftJustify = r.ctl[SACC_CTL_LEFT_JUST];

  // Checking helpers: pulse spacing and configuration settling
  logic [4:0] gapCnt;
  logic [4:0] settleCnt;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gapCnt <= 5'h01;
      settleCnt <= 5'h00;
    end else begin
      gapCnt <= r.sarClkEn ? 5'h01 : 5'(gapCnt + 5'h01);
      if (n.cfg != r.cfg) begin
        settleCnt <= 5'h00;
      end else if (settleCnt != 5'(SACC_SETTLE_CYCLES)) begin
        settleCnt <= settleCnt + 5'h01;
      end
    end
  end

  sequence s_startWrite;
    r.state == SACC_IDLE && r.ctl[SACC_CTL_ENABLE] && sfrWe && sfrAddr == SACC_CTL_ADDR &&
      sfrWrData[SACC_CTL_BUSY] && sfrWrData[SACC_CTL_ENABLE] &&
      r.ctl[SACC_CTL_START_MSB:SACC_CTL_START_LSB] == SACC_START_BY_WRITE;
  endsequence
  sequence s_busyHeld;
    converting [*2];
  endsequence

  property p_divLow;
    @(posedge ref_clk) disable iff (!rst_b)
    r.sarClkEn && settleCnt == 5'(SACC_SETTLE_CYCLES) && !r.cfg[SACC_CFG_PERIOD_MSB]
      |-> gapCnt == 5'(5'h01 << r.cfg[6:5]);
  endproperty
  a_divLow: assert property (p_divLow) else $error("SAR clock spacing wrong"); // RULE1

  property p_div16;
    @(posedge ref_clk) disable iff (!rst_b)
    r.sarClkEn && settleCnt == 5'(SACC_SETTLE_CYCLES) && r.cfg[SACC_CFG_PERIOD_MSB]
      |-> gapCnt == 5'h10;
  endproperty
  a_div16: assert property (p_div16) else $error("SAR clock not divided by 16"); // RULE2

  property p_cfgUnused;
    @(posedge ref_clk) disable iff (!rst_b)
    sfrRe && sfrAddr == SACC_CFG_ADDR |=> sfrRdData[4:3] == 2'h0;
  endproperty
  a_cfgUnused: assert property (p_cfgUnused) else $error("Unused config bits read set"); // RULE4

  property p_gain;
    @(posedge ref_clk) disable iff (!rst_b)
    settleCnt == 5'(SACC_SETTLE_CYCLES) |->
      gainLog2 == (r.cfg[2] ? 3'h4 : {1'b0, r.cfg[1:0]});
  endproperty
  a_gain: assert property (p_gain) else $error("Gain does not follow gain code"); // RULE5

  property p_track;
    @(posedge ref_clk) disable iff (!rst_b)
    tracking |-> r.ctl[SACC_CTL_ENABLE] && !converting || r.state == SACC_TRACK;
  endproperty
  a_track: assert property (p_track) else $error("Tracking during conversion"); // RULE6

  property p_trackIdle;
    @(posedge ref_clk) disable iff (!rst_b)
    // An external start in a non-write start mode leaves idle legally
    r.ctl[SACC_CTL_ENABLE] && !r.ctl[SACC_CTL_TRACK_MODE] && !converting && !ctlWrHit &&
      !extStart |=> tracking;
  endproperty
  a_trackIdle: assert property (p_trackIdle) else $error("Idle converter not tracking"); // RULE6

  property p_start;
    @(posedge ref_clk) disable iff (!rst_b)
    s_startWrite |=> s_busyHeld;
  endproperty
  a_start: assert property (p_start) else $error("Busy write did not start"); // RULE7

  property p_doneEnd;
    @(posedge ref_clk) disable iff (!rst_b)
    $fell(converting) && r.ctl[SACC_CTL_ENABLE] |-> r.ctl[SACC_CTL_DONE];
  endproperty
  a_doneEnd: assert property (p_doneEnd) else $error("Done flag not set at end"); // RULE7
endmodule : sacc_control

// File: tb/testbench.sv
// Self-checking bench for the SAR converter configuration and control block
`timescale 1ns/1ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin badCount++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  import sacc_pkg::*;
  logic ref_clk, rst_b, sfrWe, sfrRe, ctlBitData, ctlBitWe, extStart, windowHit;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rdVal;
  logic [2:0] ctlBitSel, gainLog2;
  logic sarClkEn, tracking, converting, leftJustify;
  int badCount = 0;
  int nChecks = 0;

  sacc_control dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrRdData(sfrRdData),
    .ctlBitSel(ctlBitSel), .ctlBitData(ctlBitData), .ctlBitWe(ctlBitWe),
    .extStart(extStart), .windowHit(windowHit), .sarClkEn(sarClkEn),
    .gainLog2(gainLog2), .tracking(tracking), .converting(converting),
    .leftJustify(leftJustify));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWe <= 1'b1;
    @(posedge ref_clk);
    sfrWe <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrRe <= 1'b1;
    @(posedge ref_clk);
    sfrRe <= 1'b0;
    #1 rdVal = sfrRdData;
  endtask : rd

  // Cycles until the next divider pulse, bounded
  task automatic nextPulse(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (sarClkEn !== 1'b1 && n < 40);
    if (n >= 40) begin
      badCount++;
      $display("[ERR] %0t no SAR clock pulse", $time);
      summarize();
    end
  endtask : nextPulse

  // Count edges until busy drops, bounded
  task automatic waitIdle(inout int n);
    while (converting !== 1'b0 && n < 60) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 60) begin
      badCount++;
      $display("[ERR] %0t conversion never ended", $time);
      summarize();
    end
  endtask : waitIdle

  // Period, gain and unused bits for one code in both fields
  task automatic cfgChk(input logic [2:0] c);
    int n;
    int expPeriod;
    expPeriod = c[2] ? 16 : (1 << c[1:0]);
    wr(SACC_CFG_ADDR, {c, 2'b11, c});
    rd(SACC_CFG_ADDR);
    `CHK(rdVal, {c, 2'b00, c})
    repeat (2) @(posedge ref_clk);
    #1 `CHK(gainLog2, (c[2] ? 3'h4 : {1'b0, c[1:0]}))
    repeat (40) @(posedge ref_clk);
    nextPulse(n);
    nextPulse(n);
    `CHK(n, expPeriod)
  endtask : cfgChk

  task automatic bitChk();
    @(posedge ref_clk);
    ctlBitSel <= 3'h0;
    ctlBitData <= 1'b1;
    ctlBitWe <= 1'b1;
    @(posedge ref_clk);
    ctlBitWe <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(leftJustify, 1'b1)
    rd(SACC_CTL_ADDR);
    `CHK(rdVal, 8'h01)
  endtask : bitChk

  // Software start, busy while converting, done at the end, then an abort
  task automatic convChk();
    int n;
    wr(SACC_CFG_ADDR, 8'h00);
    wr(SACC_CTL_ADDR, 8'h80);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(tracking, 1'b1)
    wr(SACC_CTL_ADDR, 8'h90);
    `CHK(converting, 1'b1)
    `CHK(tracking, 1'b0)
    rd(SACC_CTL_ADDR);
    `CHK(rdVal[SACC_CTL_BUSY], 1'b1)
    // Two edges already spent in the read
    n = 2;
    waitIdle(n);
    `CHK(n, int'(SACC_CONV_SAR_CLKS))
    rd(SACC_CTL_ADDR);
    `CHK(rdVal, 8'ha0)
    `CHK(tracking, 1'b1)
    // Slow divider so the abort lands mid-conversion
    wr(SACC_CFG_ADDR, 8'h80);
    wr(SACC_CTL_ADDR, 8'h90);
    wr(SACC_CTL_ADDR, 8'h00);
    rd(SACC_CTL_ADDR);
    `CHK(rdVal, 8'h00)
    `CHK(converting, 1'b0)
  endtask : convChk

  // External start with tracking window and window flag; busy write refused
  task automatic extChk();
    int n;
    wr(SACC_CFG_ADDR, 8'h00);
    wr(SACC_CTL_ADDR, 8'hc4);
    wr(SACC_CTL_ADDR, 8'hd4);
    `CHK(converting, 1'b0)
    @(posedge ref_clk);
    extStart <= 1'b1;
    windowHit <= 1'b1;
    @(posedge ref_clk);
    extStart <= 1'b0;
    #1 `CHK(converting, 1'b1)
    `CHK(tracking, 1'b1)
    n = 0;
    waitIdle(n);
    `CHK(n, int'(SACC_TRACK_SAR_CLKS) + int'(SACC_CONV_SAR_CLKS))
    rd(SACC_CTL_ADDR);
    `CHK(rdVal, 8'he6)
  endtask : extChk

  // Reset in mid-run clears both registers and every output
  task automatic resetChk();
    wr(SACC_CFG_ADDR, 8'h85);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    windowHit <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK({sarClkEn, gainLog2, tracking, converting, leftJustify}, 7'h00)
    `CHK(sfrRdData, 8'h00)
    @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(SACC_CFG_ADDR);
    `CHK(rdVal, SACC_CFG_RESET)
    rd(SACC_CTL_ADDR);
    `CHK(rdVal, SACC_CTL_RESET)
  endtask : resetChk

  initial begin
    rst_b = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWe = 1'b0;
    sfrRe = 1'b0;
    ctlBitSel = 3'h0;
    ctlBitData = 1'b0;
    ctlBitWe = 1'b0;
    extStart = 1'b0;
    windowHit = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(SACC_CTL_ADDR);
    `CHK(rdVal, 8'h00)
    rd(8'h00);
    `CHK(rdVal, 8'h00)
    for (int c = 0; c < 8; c++) begin
      cfgChk(3'(c));
    end
    bitChk();
    convChk();
    extChk();
    resetChk();
    summarize();
  end
endmodule : testbench
